// File: common/dsm_consts.svh
// Constants of the drive statistics and mode-select block.
// Assumes inclusion by bare name from the one design file.
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH
// Log page header fields
`define DSM_LOG_PAGE    8'h37
`define DSM_LOG_PLEN    16'h0040
`define DSM_LOG_PARLEN  8'h2C
// Command operation codes
`define DSM_OP_MSEL     8'h15
`define DSM_OP_RD6      8'h08
`define DSM_OP_RD10     8'h28
`define DSM_OP_WR6      8'h0A
`define DSM_OP_WR10     8'h2A
`define DSM_OP_WV       8'h2E
`define DSM_OP_WV16     8'h8E
// Mode-select command and list layout, sense key and additional sense codes
`define DSM_SP_BIT      0
`define DSM_HDR_LAST    8'h03
`define DSM_BD_LEN      8'h08
`define DSM_SK_ILLEGAL  4'h5
`define DSM_ASC_BADPARM 8'h26
`define DSM_ASC_PCHG    8'h2A
// Supported mode pages: code, length, base in the parameter store
`define DSM_PG_A        6'h01
`define DSM_PG_A_LEN    8'h0A
`define DSM_PG_A_BASE   6'h00
`define DSM_PG_B        6'h08
`define DSM_PG_B_LEN    8'h12
`define DSM_PG_B_BASE   6'h10
`define DSM_PG_C        6'h1C
`define DSM_PG_C_LEN    8'h0A
`define DSM_PG_C_BASE   6'h28
// Register byte addresses, log page window and word count, bus response codes
`define DSM_REG_STAT    12'h004
`define DSM_REG_UA      12'h008
`define DSM_REG_SPLO    12'h00C
`define DSM_REG_SPHI    12'h010
`define DSM_REG_FLASH   12'h014
`define DSM_LOG_HI      4'h1
`define DSM_LOG_WORDS   6'h11
`define DSM_RESP_OKAY   2'b00
`define DSM_RESP_SLVERR 2'b10
`endif

// File: common/dsm_pkg.sv
// Types shared by the drive statistics and mode-select block.
// Assumes a single clock domain and an AXI4-Lite register master.
package dsm_pkg;
   typedef enum logic [5:0] {
      S_IDLE  = 6'b00_0001,
      S_HDR   = 6'b00_0010,
      S_BDESC = 6'b00_0100,
      S_PCODE = 6'b00_1000,
      S_PLEN  = 6'b01_0000,
      S_BODY  = 6'b10_0000
   } dsm_ms_state_t;
   typedef struct packed {
      logic awvalid; logic [11:0] awaddr; logic wvalid; logic [31:0] wdata;
      logic [3:0] wstrb; logic bready; logic arvalid; logic [11:0] araddr;
      logic rready;
   } dsm_axi_req_t;
   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } dsm_axi_rsp_t;
   typedef struct packed {
      logic valid; logic [7:0] opcode; logic [7:0] byte1; logic [7:0] byte4;
      logic [2:0] initiator;
   } dsm_cdb_t;
   typedef struct packed {logic valid; logic [7:0] data;} dsm_pd_t;
   typedef struct packed {
      logic hour; logic [15:0] rd_bytes; logic [15:0] wr_bytes;
      logic temp_vld; logic [7:0] temp; logic reassign; logic ie;
      logic ie_med; logic ie_hdw; logic ie_warn; logic flash_ecc;
      logic spare_used;
   } dsm_ev_t;
   typedef struct packed {
      logic done; logic chk; logic [3:0] sense_key; logic [7:0] asc;
      logic save_req; logic [7:0] ua;
   } dsm_ms_out_t;
   typedef struct packed {
      dsm_axi_rsp_t rsp; logic aw_got; logic [11:0] awaddr;
      logic w_got; logic [31:0] wdata; logic [3:0] wstrb;
      dsm_ms_state_t ms; logic [7:0] remain; logic [7:0] cnt;
      logic [7:0] plen; logic [5:0] pbase; logic sp; logic chg;
      logic [2:0] init; dsm_ms_out_t out; logic [63:0][7:0] mode;
      logic [63:0] spare_avail; logic [31:0] hours; logic [63:0] byt_rd;
      logic [63:0] byt_wr; logic [7:0] max_temp; logic [15:0] grown_defect_list;
      logic [7:0] ie_cnt; logic med; logic hdw; logic [63:0] rd_cmd;
      logic [63:0] wr_cmd; logic [31:0] flash; logic [63:0] spare_used;
   } dsm_state_t;
endpackage

// File: rtl/dsm_stats_msel.sv
// Drive statistics log page and six-byte mode-select executor.
// Assumes command and parameter bytes come from logic on SYS_CLK.
//
// What this block does
// - Log page 37h, length 0040h, parameter 2Ch.
// - Power-on hours, big-endian, bytes 8-11.
// - Byte 28 holds highest temperature ever seen.
// - Bytes 29-30 count reassigned logical blocks.
// - Byte 31 counts exceptions, warnings excluded.
// - Exception sets media and hardware flags.
// - Count six and ten byte reads.
// - Count writes and write-verify commands.
// - Count flash ECC corrections.
// - Report used and total spare blocks.
// - Decode opcode 15h, list length byte 4.
// - Page format flag is ignored.
// - Without save, pages apply until replaced.
// - With save, request persistent store.
// - Zero list length transfers nothing, no error.
// - Parse header, optional descriptor, then pages.
// - One parameter set for all initiators.
// - Wrong page length gives illegal request.
// - A clean completion with changes posts unit attention to others.
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "dsm_consts.svh"
module dsm_stats_msel (
   input  wire logic          SYS_CLK,
   input  wire logic          RST_N,
   input  wire logic          CE,
   input  wire dsm_pkg::dsm_axi_req_t AXI_REQ,
   output dsm_pkg::dsm_axi_rsp_t      AXI_RSP,
   input  wire dsm_pkg::dsm_cdb_t     CDB,
   input  wire dsm_pkg::dsm_pd_t      PD,
   input  wire dsm_pkg::dsm_ev_t      EV,
   output dsm_pkg::dsm_ms_out_t       MS_OUT
);
   import dsm_pkg::*;

   dsm_state_t      st_ff;     // All state
   dsm_state_t      nxt_st;    // Next state
   logic [0:16][31:0] pgw;     // Log page as big-endian words
   logic            last;      // Current list byte is the final one
   logic            fail;      // Parameter list rejected
   logic            fin;       // Parameter list completed cleanly
   logic [7:0]      ua_set;    // Unit attention bits raised now
   logic [5:0]      idx;       // Parameter store index
   logic [11:0]     ra;        // Aligned read address
   logic [11:0]     wa;        // Aligned write address

   // Byte-lane merge for writable words
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         wmerge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
      end
   endfunction

   // Expected length of a supported page; zero marks unsupported
   function automatic logic [7:0] pg_len(input logic [5:0] code);
      case (code)
         `DSM_PG_A: pg_len = `DSM_PG_A_LEN;
         `DSM_PG_B: pg_len = `DSM_PG_B_LEN;
         `DSM_PG_C: pg_len = `DSM_PG_C_LEN;
         default:   pg_len = 8'h00;
      endcase
   endfunction

   // Where a page lives in the shared store
   function automatic logic [5:0] pg_base(input logic [5:0] code);
      case (code)
         `DSM_PG_B: pg_base = `DSM_PG_B_BASE;
         `DSM_PG_C: pg_base = `DSM_PG_C_BASE;
         default:   pg_base = `DSM_PG_A_BASE;
      endcase
   endfunction

   // Log page image, byte 0 in the top of word 0
   always_comb begin
      pgw = {`DSM_LOG_PAGE, 8'h00, `DSM_LOG_PLEN,
             16'h0000, 8'h00, `DSM_LOG_PARLEN,
             st_ff.hours,
             st_ff.byt_rd, st_ff.byt_wr,
             st_ff.max_temp, st_ff.grown_defect_list, st_ff.ie_cnt,
             {st_ff.med, st_ff.hdw, 6'h00},
             st_ff.rd_cmd, st_ff.wr_cmd, 24'h00_0000,
             st_ff.spare_used,
             64'(st_ff.spare_used + st_ff.spare_avail)};
   end

   // Next-state logic: bus slave, statistics, mode-select parser
   always_comb begin
      nxt_st = st_ff;
      last   = (st_ff.remain == 8'h01);
      fail   = 1'b0;
      fin    = 1'b0;
      ua_set = 8'h00;
      idx    = 6'(st_ff.pbase + st_ff.cnt[5:0]);
      ra     = {AXI_REQ.araddr[11:2], 2'b00};
      wa     = {st_ff.awaddr[11:2], 2'b00};
      nxt_st.out.done     = 1'b0;
      nxt_st.out.save_req = 1'b0;

      // Write address and data are taken independently
      if (AXI_REQ.awvalid && st_ff.rsp.awready) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = AXI_REQ.awaddr;
      end
      if (AXI_REQ.wvalid && st_ff.rsp.wready) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = AXI_REQ.wdata;
         nxt_st.wstrb = AXI_REQ.wstrb;
      end
      // Response retires first so a new write can complete next
      if (st_ff.rsp.bvalid && AXI_REQ.bready) begin
         nxt_st.rsp.bvalid = 1'b0;
      end
      // Both halves held and no response pending: commit the write
      if (st_ff.aw_got && st_ff.w_got && !st_ff.rsp.bvalid) begin
         nxt_st.aw_got     = 1'b0;
         nxt_st.w_got      = 1'b0;
         nxt_st.rsp.bvalid = 1'b1;
         nxt_st.rsp.bresp  = `DSM_RESP_OKAY;
         case (wa)
            `DSM_REG_UA: begin
               // Write one to clear; a new attention below still wins
               if (st_ff.wstrb[0]) begin
                  nxt_st.out.ua = st_ff.out.ua & ~st_ff.wdata[7:0];
               end
            end
            `DSM_REG_SPLO: begin
               nxt_st.spare_avail[31:0] =
                  wmerge(st_ff.spare_avail[31:0], st_ff.wdata, st_ff.wstrb);
            end
            `DSM_REG_SPHI: begin
               nxt_st.spare_avail[63:32] =
                  wmerge(st_ff.spare_avail[63:32], st_ff.wdata, st_ff.wstrb);
            end
            default: begin
               nxt_st.rsp.bresp = `DSM_RESP_SLVERR;
            end
         endcase
      end

      // Reads answer one cycle after the address is taken
      if (st_ff.rsp.rvalid && AXI_REQ.rready) begin
         nxt_st.rsp.rvalid = 1'b0;
      end
      if (AXI_REQ.arvalid && st_ff.rsp.arready) begin
         nxt_st.rsp.rvalid = 1'b1;
         nxt_st.rsp.rresp  = `DSM_RESP_OKAY;
         nxt_st.rsp.rdata  = 32'h0000_0000;
         if (ra[11:8] == `DSM_LOG_HI && ra[7:2] < `DSM_LOG_WORDS) begin
            // Word 16 needs five index bits; the range check keeps it in bounds
            nxt_st.rsp.rdata = pgw[5'(ra[7:2])];
         end else begin
            case (ra)
               `DSM_REG_STAT: nxt_st.rsp.rdata = {st_ff.ms != S_IDLE,
                  st_ff.out.chk, 2'b00, st_ff.out.sense_key,
                  st_ff.out.asc, 8'h00, st_ff.out.ua};
               `DSM_REG_UA:    nxt_st.rsp.rdata = {24'h00_0000, st_ff.out.ua};
               `DSM_REG_SPLO:  nxt_st.rsp.rdata = st_ff.spare_avail[31:0];
               `DSM_REG_SPHI:  nxt_st.rsp.rdata = st_ff.spare_avail[63:32];
               `DSM_REG_FLASH: nxt_st.rsp.rdata = st_ff.flash;
               default:        nxt_st.rsp.rresp = `DSM_RESP_SLVERR;
            endcase
         end
      end

      // Lifetime statistics
      if (EV.hour) begin
         nxt_st.hours = st_ff.hours + 32'h1;
      end
      nxt_st.byt_rd = st_ff.byt_rd + {48'h0000_0000_0000, EV.rd_bytes};
      nxt_st.byt_wr = st_ff.byt_wr + {48'h0000_0000_0000, EV.wr_bytes};
      if (EV.temp_vld && EV.temp > st_ff.max_temp) begin
         nxt_st.max_temp = EV.temp;
      end
      if (EV.reassign) begin
         nxt_st.grown_defect_list = st_ff.grown_defect_list + 16'h1;
      end
      // Saturates so a long life never wraps back to a small count
      if (EV.ie && !EV.ie_warn && st_ff.ie_cnt != 8'hFF) begin
         nxt_st.ie_cnt = st_ff.ie_cnt + 8'h1;
      end
      if (EV.ie) begin
         nxt_st.med = st_ff.med | EV.ie_med;
         nxt_st.hdw = st_ff.hdw | EV.ie_hdw;
      end
      if (EV.flash_ecc) begin
         nxt_st.flash = st_ff.flash + 32'h1;
      end
      if (EV.spare_used) begin
         nxt_st.spare_used = st_ff.spare_used + 64'h1;
      end
      // Command counters see every command, busy or not
      if (CDB.valid) begin
         case (CDB.opcode)
            `DSM_OP_RD6, `DSM_OP_RD10: begin
               nxt_st.rd_cmd = st_ff.rd_cmd + 64'h1;
            end
            `DSM_OP_WR6, `DSM_OP_WR10, `DSM_OP_WV, `DSM_OP_WV16: begin
               nxt_st.wr_cmd = st_ff.wr_cmd + 64'h1;
            end
            default: begin
            end
         endcase
      end

      // Mode-select start; page format bit is never looked at
      if (CDB.valid && CDB.opcode == `DSM_OP_MSEL && st_ff.ms == S_IDLE) begin
         nxt_st.sp     = CDB.byte1[`DSM_SP_BIT];
         nxt_st.remain = CDB.byte4;
         nxt_st.init   = CDB.initiator;
         nxt_st.chg    = 1'b0;
         nxt_st.cnt    = 8'h00;
         if (CDB.byte4 == 8'h00) begin
            fin = 1'b1;
         end else begin
            nxt_st.ms = S_HDR;
         end
      end else if (PD.valid && st_ff.ms != S_IDLE) begin
         nxt_st.remain = st_ff.remain - 8'h1;
         case (st_ff.ms)
            S_HDR: begin
               nxt_st.cnt = st_ff.cnt + 8'h1;
               if (st_ff.cnt == `DSM_HDR_LAST) begin
                  // Descriptor length is 0 or 8, nothing else
                  nxt_st.cnt = 8'h00;
                  if (PD.data == 8'h00) begin
                     nxt_st.ms = S_PCODE;
                  end else if (PD.data == `DSM_BD_LEN) begin
                     nxt_st.ms = S_BDESC;
                  end else begin
                     fail = 1'b1;
                  end
                  fin = last && !fail;
               end else begin
                  fail = last;
               end
            end
            S_BDESC: begin
               // Descriptor is accepted and not stored
               nxt_st.cnt = st_ff.cnt + 8'h1;
               if (st_ff.cnt == `DSM_BD_LEN - 8'h1) begin
                  nxt_st.ms = S_PCODE;
                  fin = last;
               end else begin
                  fail = last;
               end
            end
            S_PCODE: begin
               nxt_st.pbase = pg_base(PD.data[5:0]);
               nxt_st.plen  = pg_len(PD.data[5:0]);
               nxt_st.ms    = S_PLEN;
               fail = last;
            end
            S_PLEN: begin
               if (PD.data != st_ff.plen || st_ff.plen == 8'h00 || last) begin
                  fail = 1'b1;
               end else begin
                  nxt_st.cnt = 8'h00;
                  nxt_st.ms  = S_BODY;
               end
            end
            S_BODY: begin
               // One shared store, so every initiator sees the change
               if (st_ff.mode[idx] != PD.data) begin
                  nxt_st.chg = 1'b1;
               end
               nxt_st.mode[idx] = PD.data;
               nxt_st.cnt = st_ff.cnt + 8'h1;
               if (st_ff.cnt == st_ff.plen - 8'h1) begin
                  nxt_st.ms = S_PCODE;
                  fin = last;
               end else begin
                  fail = last;
               end
            end
            default: begin
               nxt_st.ms = S_IDLE;
            end
         endcase
      end

      // Completion: clean end or illegal request
      if (fail) begin
         nxt_st.ms            = S_IDLE;
         nxt_st.out.done      = 1'b1;
         nxt_st.out.chk       = 1'b1;
         nxt_st.out.sense_key = `DSM_SK_ILLEGAL;
         nxt_st.out.asc       = `DSM_ASC_BADPARM;
      end else if (fin) begin
         nxt_st.ms            = S_IDLE;
         nxt_st.out.done      = 1'b1;
         nxt_st.out.chk       = 1'b0;
         nxt_st.out.sense_key = 4'h0;
         nxt_st.out.asc       = 8'h00;
         nxt_st.out.save_req  = nxt_st.sp;
         if (nxt_st.chg) begin
            ua_set         = ~(8'h01 << nxt_st.init);
            nxt_st.out.asc = `DSM_ASC_PCHG;
         end
      end
      nxt_st.out.ua = nxt_st.out.ua | ua_set;

      // Write ready flags follow the holding registers; read ready follows the pending read response
      nxt_st.rsp.awready = !nxt_st.aw_got;
      nxt_st.rsp.wready  = !nxt_st.w_got;
      nxt_st.rsp.arready = !nxt_st.rsp.rvalid;
   end

   // State register; CE low freezes everything, pulses included
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff    <= '0;
         st_ff.ms <= S_IDLE;
      end else if (CE) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign AXI_RSP = st_ff.rsp;
   assign MS_OUT  = st_ff.out;

   default clocking dcb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   a_hours_count: assert property (CE && EV.hour |=>
      st_ff.hours == $past(st_ff.hours) + 32'h1) else $error("hours");
   a_temp_max: assert property (CE |=> st_ff.max_temp >=
      $past(st_ff.max_temp)) else $error("max temp fell");
   a_grown_defect_list_count: assert property (CE && EV.reassign |=>
      st_ff.grown_defect_list == $past(st_ff.grown_defect_list) + 16'h1) else $error("grown_defect_list");
   a_ie_warn_skip: assert property (CE && EV.ie_warn |=>
      st_ff.ie_cnt == $past(st_ff.ie_cnt)) else $error("warn counted");
   a_ie_flags_set: assert property (CE && EV.ie && EV.ie_med
      |=> st_ff.med [*2]) else $error("media flag");
   a_rd_cmd_count: assert property (CE && CDB.valid &&
      (CDB.opcode == `DSM_OP_RD6 || CDB.opcode == `DSM_OP_RD10) |=>
      st_ff.rd_cmd == $past(st_ff.rd_cmd) + 64'h1) else $error("rd cmd");
   a_wr_cmd_count: assert property (CE && CDB.valid &&
      CDB.opcode == `DSM_OP_WV16 |=>
      st_ff.wr_cmd == $past(st_ff.wr_cmd) + 64'h1) else $error("wr cmd");
   a_zero_len_ok: assert property (CE && CDB.valid &&
      CDB.opcode == `DSM_OP_MSEL && CDB.byte4 == 8'h00 &&
      st_ff.ms == S_IDLE |=> MS_OUT.done && !MS_OUT.chk)
      else $error("zero length");
   a_bad_plen: assert property (CE && PD.valid &&
      st_ff.ms == S_PLEN && PD.data != st_ff.plen |=> MS_OUT.done &&
      MS_OUT.chk && MS_OUT.sense_key == `DSM_SK_ILLEGAL)
      else $error("bad page length");
   a_save_only_ok: assert property (MS_OUT.save_req |->
      MS_OUT.done && !MS_OUT.chk) else $error("save on error");
   a_ua_sender: assert property (CE && st_ff.ms != S_IDLE
      ##1 MS_OUT.done |-> MS_OUT.ua[st_ff.init] ==
      $past(MS_OUT.ua[st_ff.init]) || !$past(CE))
      else $error("sender got attention");
   a_bvalid_hold: assert property (AXI_RSP.bvalid &&
      !AXI_REQ.bready |=> AXI_RSP.bvalid) else $error("bvalid dropped");

   c_ms_ok: cover property (MS_OUT.done && !MS_OUT.chk && MS_OUT.ua != 8'h00);
   c_ms_err: cover property (MS_OUT.done && MS_OUT.chk);
   c_ms_save: cover property (MS_OUT.save_req);
   c_log_read: cover property (AXI_RSP.rvalid && AXI_REQ.rready);
endmodule // dsm_stats_msel

// File: test/dsm_initiator_model.sv
// Initiator model: sends command blocks and mode-select parameter lists.
// Assumes the block samples the command and list ports on rising sys_clk.
`timescale 1ns/100ps
module dsm_initiator_model (
   input  wire logic                  sys_clk,
   output dsm_pkg::dsm_cdb_t          cdb,
   output dsm_pkg::dsm_pd_t           pd,
   input  wire dsm_pkg::dsm_ms_out_t  ms_out
);
   import dsm_pkg::*;

   // Ports idle until the bench asks for a command
   initial begin
      cdb = '0;
      pd  = '0;
   end

   // One command block for one cycle; fields are scrambled once withdrawn
   task automatic cmd(input logic [7:0] op, b1, b4, input logic [2:0] id);
      @(posedge sys_clk);
      cdb <= {1'b1, op, b1, b4, id};
      @(posedge sys_clk);
      cdb <= {1'b0, ~op, ~b1, ~b4, ~id};
   endtask

   // Header, optional descriptor, one page; byte 4 counts the whole list
   task automatic ms(input logic [7:0] b1, bd, pc, pl, fill, nb, input logic [2:0] id);
      logic [7:0] lst [$];
      lst = {8'h00, 8'h00, 8'h00, bd};
      repeat (bd) lst.push_back(8'h00);
      lst.push_back(pc);
      // Length as the block expects it, unless a test wants it wrong
      lst.push_back(pl);
      repeat (nb) lst.push_back(fill);
      cmd(8'h15, b1, 8'(lst.size()), id);
      // Bytes back to back, the hardest spacing for the parser
      foreach (lst[i]) begin
         pd <= {1'b1, lst[i]};
         @(posedge sys_clk);
      end
      // A released data line shows the inverse, never a stale byte
      pd <= {1'b0, ~lst[lst.size()-1]};
   endtask

   // Bounded wait for the one-cycle completion pulse, status kept;
   // the current cycle is looked at first, since done can rise at the
   // very edge on which the last command or list byte was taken
   task automatic wait_done(output logic ok, output dsm_ms_out_t res);
      ok  = 1'b0;
      res = '0;
      for (int i = 0; i < 40 && ok == 1'b0; i++) begin
         #1;
         if (ms_out.done === 1'b1) begin
            ok  = 1'b1;
            res = ms_out;
         end else begin
            @(posedge sys_clk);
         end
      end
   endtask
endmodule // dsm_initiator_model

// File: test/tb_top.sv
// Bench: registers over AXI4-Lite, drive event pulses, mode select.
// Assumes the block and the initiator model share one 40 MHz clock.
`timescale 1ns/100ps
module tb_top;
   import dsm_pkg::*;
   logic         sys_clk;     // 25 ns clock
   logic         rst_n;       // Active-low reset
   logic         ce;          // Clock enable
   dsm_axi_req_t areq;        // Bus master side
   dsm_axi_rsp_t arsp;        // Bus answers
   dsm_cdb_t     cdb;         // Commands from the model
   dsm_pd_t      pd;          // List bytes from the model
   dsm_ev_t      ev;          // Event pulses
   dsm_ms_out_t  ms_out;      // Mode-select status
   dsm_ms_out_t  res;         // Captured completion
   logic         ok;          // Completion seen
   logic [31:0]  rd;          // Last read data
   logic [1:0]   rsp;         // Last bus response
   int           err_count;   // Mismatches
   int           num_checks;  // Comparisons
   // Counted opcodes, plus one that must not count
   logic [7:0]   ops [7] = '{8'h08, 8'h28, 8'h0A, 8'h2A, 8'h2E, 8'h8E, 8'h12};

   // Clock enable driven by the bench so that freezing is exercised
   dsm_stats_msel i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(ce), .AXI_REQ(areq),
      .AXI_RSP(arsp), .CDB(cdb), .PD(pd), .EV(ev), .MS_OUT(ms_out));
   dsm_initiator_model i_init (.sys_clk(sys_clk), .cdb(cdb), .pd(pd), .ms_out(ms_out));

   // Free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Counts a comparison, reports a mismatch at once
   task automatic cmp(input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // A wait that ran out counts as a mismatch and ends the run
   task automatic hang(input logic seen);
      if (seen !== 1'b1) begin
         err_count++;
         wrap_up();
      end
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      logic aw, w, b;
      aw = 1'b1;
      w  = 1'b1;
      b  = 1'b0;
      @(posedge sys_clk);
      areq.awvalid <= 1'b1;
      areq.awaddr  <= a;
      areq.wvalid  <= 1'b1;
      areq.wdata   <= d;
      areq.wstrb   <= 4'hF;
      areq.bready  <= 1'b1;
      for (int i = 0; i < 50 && !b; i++) begin
         @(posedge sys_clk);
         aw = aw & ~arsp.awready;
         w  = w & ~arsp.wready;
         areq.awvalid <= aw;
         areq.wvalid  <= w;
         if (arsp.bvalid === 1'b1) begin
            b   = 1'b1;
            rsp = arsp.bresp;
            areq.bready <= 1'b0;
         end
      end
      hang(b);
   endtask

   // Read: rready held until rvalid is sampled
   task automatic axr(input logic [11:0] a);
      logic ar, r;
      ar = 1'b1;
      r  = 1'b0;
      @(posedge sys_clk);
      areq.arvalid <= 1'b1;
      areq.araddr  <= a;
      areq.rready  <= 1'b1;
      for (int i = 0; i < 50 && !r; i++) begin
         @(posedge sys_clk);
         ar = ar & ~arsp.arready;
         areq.arvalid <= ar;
         if (arsp.rvalid === 1'b1) begin
            r   = 1'b1;
            rd  = arsp.rdata;
            rsp = arsp.rresp;
            areq.rready <= 1'b0;
         end
      end
      hang(r);
   endtask

   // Read and compare one word
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      axr(a);
      cmp(rd, e);
   endtask

   // One-cycle event pulse
   task automatic pulse(input dsm_ev_t e);
      @(posedge sys_clk);
      ev <= e;
      @(posedge sys_clk);
      ev <= '0;
   endtask

   // Completion: check flag, additional code, save request, attention bits
   task automatic msck(input logic c, input logic [7:0] asc, input logic s, input logic [7:0] u);
      i_init.wait_done(ok, res);
      hang(ok);
      cmp({14'h0, res.chk, res.asc, res.save_req, res.ua}, {14'h0, c, asc, s, u});
   endtask

   // Verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      err_count  = 0;
      num_checks = 0;
      rst_n      = 1'b0;
      areq       = '0;
      ev         = '0;
      ce         = 1'b1;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rc(12'h100, 32'h3700_0040);
      rc(12'h104, 32'h0000_002C);
      $display("test header finished");
      // Lifetime events; the lower temperature must not replace the peak
      repeat (3) pulse(dsm_ev_t'{hour: 1'b1, default: '0});
      pulse(dsm_ev_t'{rd_bytes: 16'h0005, wr_bytes: 16'h0007, default: '0});
      pulse(dsm_ev_t'{temp_vld: 1'b1, temp: 8'h2D, default: '0});
      pulse(dsm_ev_t'{temp_vld: 1'b1, temp: 8'h1E, default: '0});
      repeat (2) pulse(dsm_ev_t'{reassign: 1'b1, default: '0});
      pulse(dsm_ev_t'{ie: 1'b1, ie_med: 1'b1, default: '0});
      pulse(dsm_ev_t'{ie: 1'b1, ie_hdw: 1'b1, default: '0});
      pulse(dsm_ev_t'{ie: 1'b1, ie_warn: 1'b1, default: '0});
      repeat (2) pulse(dsm_ev_t'{flash_ecc: 1'b1, default: '0});
      pulse(dsm_ev_t'{spare_used: 1'b1, default: '0});
      rc(12'h108, 32'h0000_0003);
      // An hour pulse while the enable is low must be lost
      @(posedge sys_clk);
      ce <= 1'b0;
      pulse(dsm_ev_t'{hour: 1'b1, default: '0});
      ce <= 1'b1;
      rc(12'h108, 32'h0000_0003);
      rc(12'h110, 32'h0000_0005);
      rc(12'h118, 32'h0000_0007);
      rc(12'h11C, 32'h2D00_0202);
      rc(12'h120, 32'hC000_0000);
      rc(12'h014, 32'h0000_0002);
      axw(12'h014, 32'hFFFF_FFFF);
      cmp({30'h0, rsp}, 32'h0000_0002);
      rc(12'h014, 32'h0000_0002);
      rc(12'h138, 32'h0000_0001);
      axw(12'h00C, 32'h0000_0010);
      cmp({30'h0, rsp}, 32'h0000_0000);
      rc(12'h140, 32'h0000_0011);
      axr(12'h0F0);
      cmp({rd[29:0], rsp}, 32'h0000_0002);
      $display("test statistics finished");
      foreach (ops[i]) i_init.cmd(ops[i], 8'h00, 8'h00, 3'd0);
      rc(12'h128, 32'h0200_0000);
      rc(12'h130, 32'h0400_0000);
      $display("test command counts finished");
      i_init.cmd(8'h15, 8'h00, 8'h00, 3'd1);
      msck(1'b0, 8'h00, 1'b0, 8'h00);
      i_init.ms(8'h01, 8'h00, 8'h01, 8'h0A, 8'h5A, 8'h0A, 3'd2);
      msck(1'b0, 8'h2A, 1'b1, 8'hFB);
      rc(12'h008, 32'h0000_00FB);
      axw(12'h008, 32'h0000_00FF);
      rc(12'h008, 32'h0000_0000);
      i_init.ms(8'h10, 8'h08, 8'h1C, 8'h0A, 8'hA5, 8'h0A, 3'd5);
      msck(1'b0, 8'h2A, 1'b0, 8'hDF);
      axw(12'h008, 32'h0000_00FF);
      i_init.ms(8'h00, 8'h00, 8'h08, 8'h0A, 8'h00, 8'h00, 3'd3);
      msck(1'b1, 8'h26, 1'b0, 8'h00);
      rc(12'h004, 32'h4526_0000);
      $display("test mode select finished");
      wrap_up();
   end
endmodule // tb_top
